/* File: core/lcd_drive_contrast_and_segment_memory.sv */
// Segment display drive-time, contrast and display memory registers.
// Assumes a classic Wishbone master and a frame-start pulse on this clock.
//
// Functional notes
// - Three-bit code picks drive time 70..1150 us, or half prescaled period
// - Drive time never exceeds half the prescaled clock period
// - Static duty or blanking forces drive time to half the period
// - New drive code acts at once, glitches allowed
// - Four-bit contrast code sets 2.60 V plus 0.05 V per step
// - Written contrast code waits pending until next frame start
// - Bit 4 of drive and contrast register is read-only zero
// - A memory bit set to one energizes its segment
// - Unused memory bits stay readable and writable storage
// - Prescaled clock is tap 16..4096 times divider factor
`default_nettype none

module lcd_drive_contrast_and_segment_memory #(
    parameter int unsigned DRIVE_CYC_300 = lcd_drive_pkg::DRIVE_CYC_C0,
    parameter int unsigned DRIVE_CYC_150 = lcd_drive_pkg::DRIVE_CYC_C2,
    parameter int unsigned DRIVE_CYC_450 = lcd_drive_pkg::DRIVE_CYC_C3,
    parameter int unsigned DRIVE_CYC_575 = lcd_drive_pkg::DRIVE_CYC_C4,
    parameter int unsigned DRIVE_CYC_850 = lcd_drive_pkg::DRIVE_CYC_C5,
    parameter int unsigned DRIVE_CYC_1150 = lcd_drive_pkg::DRIVE_CYC_C6
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic frame_start_i,
    output logic [159:0] seg_map_o,
    output logic drive_on_o,
    output logic prescaled_display_clock_o,
    output logic [3:0] contrast_voltage_select_o,
    output logic [11:0] vlcd_target_mv_o
);

    localparam int NREG = int'(lcd_drive_pkg::NUM_DATA_REGS);

    // Bus decode

    logic ack_r;
    logic req;
    logic wr_lo;
    logic [7:0] idx;
    logic in_data;
    logic [4:0] data_off;
    logic [7:0] last_idx_r;
    logic last_rd_r;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // Only lane 0 carries the 8-bit registers; other lanes are ignored
    assign wr_lo = req & wb_we_i & wb_sel_i[0];
    // Upper bound needs nine bits: the last data index is 0xFF
    assign in_data = (idx >= lcd_drive_pkg::IDX_DATA_BASE) &&
        ({1'b0, idx} < {1'b0, lcd_drive_pkg::IDX_DATA_BASE} +
         {1'b0, lcd_drive_pkg::NUM_DATA_REGS});
    assign data_off = 5'(idx - lcd_drive_pkg::IDX_DATA_BASE);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            last_idx_r <= 8'h00;
            last_rd_r <= 1'b0;
        end else if (req) begin
            last_idx_r <= idx;
            last_rd_r <= ~wb_we_i;
        end
    end

    assign wb_ack_o = ack_r;

    // Control registers

    logic [7:0] drive_contrast_r;
    logic [7:0] cfg_r;
    logic [3:0] contrast_applied_r;
    logic contrast_pend_r;
    logic wr_drive;

    assign wr_drive = wr_lo && idx == lcd_drive_pkg::IDX_DRIVE_CONTRAST;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            drive_contrast_r <= lcd_drive_pkg::REG_RESET;
        end else if (wr_drive) begin
            // Reserved bit is never stored
            drive_contrast_r <= wb_dat_i[7:0] &
                lcd_drive_pkg::DRIVE_CONTRAST_WMASK;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_r <= lcd_drive_pkg::REG_RESET;
        end else if (wr_lo && idx == lcd_drive_pkg::IDX_CONFIG) begin
            cfg_r <= wb_dat_i[7:0];
        end
    end

    // Contrast moves only at a frame boundary to keep levels steady
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            contrast_applied_r <= 4'h0;
        end else if (frame_start_i) begin
            contrast_applied_r <= drive_contrast_r[3:0];
        end
    end

    // A write in the frame-start cycle stays pending: set beats clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            contrast_pend_r <= 1'b0;
        end else if (wr_drive) begin
            contrast_pend_r <= 1'b1;
        end else if (frame_start_i) begin
            contrast_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            vlcd_target_mv_o <= lcd_drive_pkg::VLCD_BASE_MV;
        end else begin
            vlcd_target_mv_o <= 12'(lcd_drive_pkg::VLCD_BASE_MV +
                {8'h00, contrast_applied_r} *
                lcd_drive_pkg::VLCD_STEP_MV);
        end
    end

    assign contrast_voltage_select_o = contrast_applied_r;

    // Display memory

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_seg
            logic [7:0] byte_r;
            always_ff @(posedge ref_clk_i) begin
                if (rst_i) begin
                    byte_r <= lcd_drive_pkg::REG_RESET;
                end else if (wr_lo && in_data && data_off == 5'(g)) begin
                    byte_r <= wb_dat_i[7:0];
                end
            end
            // Byte g covers common g/5, segments (g%5)*8 upward
            assign seg_map_o[g*8 +: 8] = byte_r;
        end
    endgenerate

    // Prescaled clock

    logic [2:0] div_sel;
    logic [2:0] tap_sel;
    logic static_duty;
    logic blanking;
    logic [15:0] period_len;
    logic [15:0] half_len;
    logic [15:0] ps_cnt_r;
    logic ps_tick;
    logic pclk_r;

    assign div_sel = cfg_r[lcd_drive_pkg::CFG_DIV_LSB +: 3];
    assign tap_sel = cfg_r[lcd_drive_pkg::CFG_TAP_LSB +: 3];
    assign static_duty = cfg_r[lcd_drive_pkg::CFG_STATIC_BIT];
    assign blanking = cfg_r[lcd_drive_pkg::CFG_BLANK_BIT];

    assign period_len = 16'(({13'h0000, div_sel} + 16'h0001) <<
        lcd_drive_pkg::tap_shift(tap_sel));
    assign half_len = period_len >> 1;
    // Wrap with >= so a shorter period never strands the counter
    assign ps_tick = (ps_cnt_r >= period_len - 16'h0001);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ps_cnt_r <= 16'h0000;
        end else if (ps_tick) begin
            ps_cnt_r <= 16'h0000;
        end else begin
            ps_cnt_r <= ps_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pclk_r <= 1'b0;
        end else begin
            pclk_r <= (ps_cnt_r < half_len);
        end
    end

    assign prescaled_display_clock_o = pclk_r;

    // Drive time selection

    logic [2:0] drive_code;
    logic [15:0] nominal_len;
    logic [15:0] drive_len;
    logic [15:0] elapsed;

    assign drive_code = drive_contrast_r[lcd_drive_pkg::DRIVE_LSB +: 3];

    always_comb begin
        case (drive_code)
            3'b000: nominal_len = 16'(DRIVE_CYC_300);
            3'b001: nominal_len = 16'(lcd_drive_pkg::DRIVE_CYC_C1);
            3'b010: nominal_len = 16'(DRIVE_CYC_150);
            3'b011: nominal_len = 16'(DRIVE_CYC_450);
            3'b100: nominal_len = 16'(DRIVE_CYC_575);
            3'b101: nominal_len = 16'(DRIVE_CYC_850);
            3'b110: nominal_len = 16'(DRIVE_CYC_1150);
            default: nominal_len = half_len;
        endcase
    end

    always_comb begin
        if (static_duty || blanking) begin
            drive_len = half_len;
        end else if (nominal_len > half_len) begin
            drive_len = half_len;
        end else begin
            drive_len = nominal_len;
        end
    end

    // Code is read live, so a rewrite changes the running pulse
    lcd_drive_timer #(
        .W(16)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(ps_tick),
        .len_i(drive_len),
        .drive_on_o(drive_on_o),
        .elapsed_o(elapsed)
    );

    // Read path

    logic [7:0] rd_byte;
    logic [31:0] dat_r;

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            lcd_drive_pkg::IDX_DRIVE_CONTRAST: rd_byte = drive_contrast_r;
            lcd_drive_pkg::IDX_CONFIG: rd_byte = cfg_r;
            lcd_drive_pkg::IDX_STATUS: begin
                rd_byte = {2'b00, drive_on_o, contrast_pend_r,
                    contrast_applied_r};
            end
            default: begin
                if (in_data) begin
                    rd_byte = seg_map_o[data_off*8 +: 8];
                end
            end
        endcase
    end

    // Unmapped reads answer zero; the bus never stalls
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_dat_o = dat_r;

    // Checks

    a_reserved_zero:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wb_ack_o && last_rd_r &&
         last_idx_r == lcd_drive_pkg::IDX_DRIVE_CONTRAST)
        |-> wb_dat_o[lcd_drive_pkg::RSVD_BIT] == 1'b0)
    else $error("reserved bit read back as one");

    a_contrast_hold:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $changed(contrast_applied_r) |-> $past(frame_start_i))
    else $error("contrast changed outside a frame start");

    a_contrast_apply:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (frame_start_i && !wr_drive) |=>
        (contrast_voltage_select_o == $past(drive_contrast_r[3:0])
         && !contrast_pend_r))
    else $error("pending contrast not applied at frame start");

    a_contrast_volts:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (contrast_applied_r == 4'hF && $stable(contrast_applied_r))
        |=> vlcd_target_mv_o == 12'hD16)
    else $error("contrast code 15 does not give 3.35 V");

    a_half_forced:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (static_duty || blanking) |-> drive_len == (period_len >> 1))
    else $error("static or blank drive is not half period");

    // A shorter period may cut a running pulse; it must end at once
    a_drive_capped:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (drive_on_o && !ps_tick && elapsed >= half_len) |=> !drive_on_o)
    else $error("drive time exceeded half prescaled period");

    a_code_short:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (drive_code == 3'b001 && !static_duty && !blanking &&
         half_len >= 16'(lcd_drive_pkg::DRIVE_CYC_C1))
        |-> drive_len == 16'(lcd_drive_pkg::DRIVE_CYC_C1))
    else $error("code 1 does not select 70 us");

    a_seg_first:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_lo && idx == lcd_drive_pkg::IDX_DATA_BASE)
        |=> seg_map_o[7:0] == $past(wb_dat_i[7:0]))
    else $error("segment byte 0 did not take the write");

    a_seg_last:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_lo && idx == lcd_drive_pkg::IDX_DATA_BASE + 8'h13)
        |=> seg_map_o[159:152] == $past(wb_dat_i[7:0]))
    else $error("last memory byte is not common 3 top segments");

    a_reset_clear:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(rst_i) |-> (seg_map_o == '0 && drive_contrast_r == 8'h00))
    else $error("registers not cleared by reset");

    a_prescale_wrap:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ps_cnt_r == period_len - 16'h0001) |=> ps_cnt_r == 16'h0000)
    else $error("prescaler did not wrap at its period");

endmodule

`default_nettype wire

/* File: core/lcd_drive_pkg.sv */
// Constants for the segment display drive and memory block.
// Assumes a single 40 MHz clock and a 32-bit classic Wishbone slave.
`default_nettype none

package lcd_drive_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_US = 1000;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_DRIVE_CONTRAST = 8'hE7;
    localparam logic [7:0] IDX_CONFIG = 8'hEA;
    localparam logic [7:0] IDX_STATUS = 8'hEB;
    localparam logic [7:0] IDX_DATA_BASE = 8'hEC;
    localparam logic [7:0] NUM_DATA_REGS = 8'h14;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DRIVE_CONTRAST_WMASK = 8'hEF;

    // Field positions
    localparam int DRIVE_LSB = 5;
    localparam int RSVD_BIT = 4;
    localparam int CFG_DIV_LSB = 0;
    localparam int CFG_STATIC_BIT = 3;
    localparam int CFG_TAP_LSB = 4;
    localparam int CFG_BLANK_BIT = 7;

    // Nominal drive times in microseconds, codes 0 to 6
    localparam int DRIVE_US_C0 = 300;
    localparam int DRIVE_US_C1 = 70;
    localparam int DRIVE_US_C2 = 150;
    localparam int DRIVE_US_C3 = 450;
    localparam int DRIVE_US_C4 = 575;
    localparam int DRIVE_US_C5 = 850;
    localparam int DRIVE_US_C6 = 1150;
    localparam int DRIVE_CYC_C0 = DRIVE_US_C0 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C1 = DRIVE_US_C1 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C2 = DRIVE_US_C2 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C3 = DRIVE_US_C3 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C4 = DRIVE_US_C4 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C5 = DRIVE_US_C5 * NS_PER_US / CLK_PERIOD_NS;
    localparam int DRIVE_CYC_C6 = DRIVE_US_C6 * NS_PER_US / CLK_PERIOD_NS;
    localparam logic [2:0] DRIVE_CODE_HALF = 3'b111;

    // Contrast target in millivolts
    localparam logic [11:0] VLCD_BASE_MV = 12'hA28;
    localparam logic [11:0] VLCD_STEP_MV = 12'h032;

    typedef enum logic {
        DRV_IDLE = 1'b0,
        DRV_ON = 1'b1
    } drive_state_e;

    // Prescaler taps 16, 64, 128 ... 4096 as a shift amount
    function automatic logic [3:0] tap_shift(input logic [2:0] tap);
        return (tap == 3'h0) ? 4'h4 : 4'({1'b0, tap} + 4'h5);
    endfunction

endpackage

`default_nettype wire

/* File: core/lcd_drive_timer.sv */
// Drive-on timer: holds the drivers on after each voltage transition.
// Assumes start and length come from logic on the same clock.
`default_nettype none

module lcd_drive_timer #(
    parameter int W = 16
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] len_i,
    output logic drive_on_o,
    output logic [W-1:0] elapsed_o
);

    lcd_drive_pkg::drive_state_e state_r;
    logic [W-1:0] elapsed_r;

    // Length is compared live, so a new code cuts or stretches a pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= lcd_drive_pkg::DRV_IDLE;
            elapsed_r <= '0;
        end else begin
            case (state_r)
                lcd_drive_pkg::DRV_IDLE: begin
                    if (start_i) begin
                        state_r <= lcd_drive_pkg::DRV_ON;
                        elapsed_r <= W'(1);
                    end
                end
                lcd_drive_pkg::DRV_ON: begin
                    if (start_i) begin
                        elapsed_r <= W'(1);
                    end else if (elapsed_r >= len_i) begin
                        state_r <= lcd_drive_pkg::DRV_IDLE;
                    end else begin
                        elapsed_r <= elapsed_r + W'(1);
                    end
                end
                default: state_r <= lcd_drive_pkg::DRV_IDLE;
            endcase
        end
    end

    assign drive_on_o = (state_r == lcd_drive_pkg::DRV_ON);
    assign elapsed_o = elapsed_r;

    a_drive_ends_live:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (drive_on_o && !start_i && elapsed_r >= len_i) |=> !drive_on_o)
    else $error("drive pulse outlived its current length");

    a_drive_starts:
    assert property (@(posedge ref_clk_i) disable iff (rst_i)
        start_i |=> (drive_on_o && elapsed_r == W'(1)))
    else $error("drive pulse did not start after a transition");

endmodule

`default_nettype wire

/* File: verification/lcd_glass_model.sv */
// Passive segment glass on the common and segment pins.
// Assumes the driver's outputs are registered on the same clock.
`default_nettype none

module lcd_glass_model (
    input wire logic ref_clk_i,
    input wire logic [159:0] seg_map_i,
    input wire logic drive_on_i,
    output logic [3:0][39:0] lit_o,
    output int pulses_o,
    output int last_len_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int run = 0;

    // Each common line sees its own forty segment plates
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            lit_o[c] = seg_map_i[c*40 +: 40];
        end
    end

    // Drive-on time per transition, as the glass would see it
    initial begin
        pulses_o = 0;
        last_len_o = 0;
    end
    always @(posedge ref_clk_i) begin
        if (drive_on_i === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_len_o <= run;
            pulses_o <= pulses_o + 1;
            run <= 0;
        end
    end
endmodule

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the display drive and memory block.
// Assumes a glass model on the outputs and Wishbone tasks as master.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, frame = 0;
    logic [9:0] adr = '0;
    logic [3:0] sel = '0;
    logic [3:0] lane = 4'h1;
    logic [31:0] wdat = '0, rdat;
    logic ack, drive_on, pclk;
    logic [3:0] cc;
    logic [11:0] mv;
    logic [159:0] seg_map;
    logic [3:0][39:0] lit;
    int miscompares = 0, check_count = 0, cycles = 0, pulses, last_len;

    always #12.5 ref_clk_i = ~ref_clk_i;

    // Code 5 keeps its real count, so here it is always capped
    lcd_drive_contrast_and_segment_memory #(.DRIVE_CYC_300(12),
        .DRIVE_CYC_150(6), .DRIVE_CYC_450(18), .DRIVE_CYC_575(23),
        .DRIVE_CYC_1150(46)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .frame_start_i(frame), .seg_map_o(seg_map), .drive_on_o(drive_on),
        .prescaled_display_clock_o(pclk), .contrast_voltage_select_o(cc),
        .vlcd_target_mv_o(mv));

    lcd_glass_model glass (.ref_clk_i(ref_clk_i), .seg_map_i(seg_map),
        .drive_on_i(drive_on), .lit_o(lit), .pulses_o(pulses),
        .last_len_o(last_len));

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Master waits for ack with no assumed latency
    task automatic xfer(logic [7:0] idx, logic w, logic [7:0] d,
                        output logic [7:0] q);
        int n;
        @(posedge ref_clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= lane;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) chk("ack", 0, 1);
        q = rdat[7:0];
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [7:0] q;
        xfer(idx, 1'b1, d, q);
    endtask

    task automatic rd(logic [7:0] idx, output logic [7:0] q);
        xfer(idx, 1'b0, 8'h00, q);
    endtask

    task automatic frame_pulse();
        @(posedge ref_clk_i);
        frame <= 1;
        @(posedge ref_clk_i);
        frame <= 0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    // Skips a pulse cut short by a settings change
    task automatic get_pulse(output int len);
        int c0, n;
        c0 = pulses;
        n = 0;
        while (pulses < c0 + 2 && n < 400) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 400) chk("pulse", 0, 1);
        len = last_len;
    endtask

    function automatic logic [7:0] pat(int r);
        return 8'(r * 37 + 90);
    endfunction

    task automatic t_reset();
        logic [7:0] q;
        chk("vlcd", 32'(mv), 32'hA28);
        rd(8'hE7, q);
        chk("ctrl", 32'(q), 0);
        for (int r = 0; r < 20; r++) begin
            rd(8'(8'hEC + r), q);
            chk("data", 32'(q), 0);
        end
        rd(8'h80, q);
        chk("unmapped", 32'(q), 0);
        $display("reset test done");
    endtask

    task automatic t_contrast();
        logic [7:0] q;
        logic [3:0] c, prev;
        prev = 0;
        for (int i = 1; i <= 16; i++) begin
            c = 4'(i);
            wr(8'hE7, {4'h1, c});
            rd(8'hE7, q);
            chk("ctrl", 32'(q), 32'(c));
            chk("pending", 32'(cc), 32'(prev));
            rd(8'hEB, q);
            chk("pend set", 32'(q[4]), 1);
            chk("applied", 32'(q[3:0]), 32'(prev));
            frame_pulse();
            chk("code", 32'(cc), 32'(c));
            chk("vlcd", 32'(mv), 2600 + 50 * c);
            rd(8'hEB, q);
            chk("pend clear", 32'(q[4]), 0);
            prev = c;
        end
        // Write and frame start taken at one edge: the old code applies
        fork
            wr(8'hE7, 8'h05);
            begin
                @(posedge ref_clk_i);
                frame <= 1;
                @(posedge ref_clk_i);
                frame <= 0;
            end
        join
        chk("same edge", 32'(cc), 0);
        rd(8'hEB, q);
        chk("pend kept", 32'(q[4]), 1);
        frame_pulse();
        chk("code", 32'(cc), 32'h5);
        $display("contrast test done");
    endtask

    task automatic t_memory();
        logic [7:0] q;
        for (int r = 0; r < 20; r++) wr(8'(8'hEC + r), pat(r));
        for (int r = 0; r < 20; r++) begin
            rd(8'(8'hEC + r), q);
            chk("data", 32'(q), 32'(pat(r)));
        end
        // Lane 0 off: the write is acked but must not land
        lane = 4'h0;
        wr(8'hEC, 8'h00);
        lane = 4'h1;
        rd(8'hEC, q);
        chk("lane off", 32'(q), 32'(pat(0)));
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 40; s++) begin
                q = pat(c * 5 + s / 8);
                chk("segment", 32'(lit[c][s]), 32'(q[s%8]));
            end
        end
        $display("memory test done");
    endtask

    task automatic t_rerst();
        logic [7:0] q;
        @(posedge ref_clk_i);
        rst_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 0;
        @(posedge ref_clk_i);
        chk("seg_map", 32'(seg_map != '0), 0);
        chk("vlcd", 32'(mv), 32'hA28);
        rd(8'hE7, q);
        chk("ctrl", 32'(q), 0);
        rd(8'hF0, q);
        chk("data", 32'(q), 0);
        $display("second reset test done");
    endtask

    task automatic t_drive();
        logic [7:0] cfg[14] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10,
            8'h10, 8'h10, 8'h20, 8'h20, 8'h20, 8'h18, 8'h01, 8'h02};
        logic [2:0] code[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 5, 6, 7, 2, 7, 7};
        int exp[14] = '{12, 32, 6, 18, 23, 32, 32, 32, 64, 46, 64, 32, 16,
            24};
        int len;
        int n;
        // No frame start is given: each code must act on its own
        for (int i = 0; i < 14; i++) begin
            wr(8'hEA, cfg[i]);
            wr(8'hE7, {code[i], 5'h00});
            get_pulse(len);
            chk("drive", len, exp[i]);
        end
        wr(8'hEA, 8'h90);
        frame_pulse();
        wr(8'hE7, 8'h40);
        get_pulse(len);
        chk("blanked", len, 32);
        // Period 64: the prescaled clock is high for exactly half of it
        n = 0;
        repeat (64) begin
            @(posedge ref_clk_i);
            n += int'(pclk);
        end
        chk("pclk", n, 32);
        $display("drive test done");
    endtask

    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 0;
        @(posedge ref_clk_i);
        t_reset();
        t_contrast();
        t_memory();
        t_rerst();
        t_drive();
        close_out();
    end
endmodule

`default_nettype wire
